//--- hw/rsd_defs.svh
// constants for the reference select and divider configuration block
// assumes the including file uses them as sized part selects and values
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH

// register word indices, byte address is four times the index
`define RSD_ADDR_W        6
`define RSD_IDX_W         4
`define RSD_IDX_CTRL      4'h0
`define RSD_IDX_STATUS    4'h1
`define RSD_IDX_PLLCFG    4'h2
`define RSD_IDX_PLLST     4'h6
`define RSD_IDX_ODIV      4'ha
`define RSD_IDX_LAST      4'hf

// control word fields
`define RSD_CTRL_W        10
`define RSD_CTRL_PSS      0
`define RSD_CTRL_MODE     2:1
`define RSD_CTRL_AUTO     2
`define RSD_CTRL_TRIM     7:3
`define RSD_CTRL_DRIVE    9:8
`define RSD_CTRL_RST      10'h300

// pll configuration word fields
`define RSD_PLL_W         23
`define RSD_PLL_D         6:0
`define RSD_PLL_N         18:7
`define RSD_PLL_A         22:19
`define RSD_PLL_RST       23'h00_0001
`define RSD_PLL_M_W       14
`define RSD_PLL3_D_MIN    7'h03

// output divider word fields
`define RSD_ODIV_W        10
`define RSD_ODIV_Q        6:0
`define RSD_ODIV_PATH     7
`define RSD_ODIV_DIS      9:8
`define RSD_ODIV_RST      10'h000
`define RSD_Q_ALLONES     7'h7f
`define RSD_DIS_LOW       2'b00
`define RSD_DIS_HIGH      2'b01
`define RSD_DIS_HIZ       1

// load capacitance in eighths of a pF: 3.5 pF base
`define RSD_CAP_BASE      6'h1c

// secondary cycles without a primary edge that mean loss
`define RSD_LOSS_CNT      2'h2

`endif

//--- hw/rsd_pkg.sv
// types shared by the reference select and divider configuration block
// assumes nothing of its surroundings
package rsd_pkg;

   typedef enum logic [2:0] {
      st_run  = 3'b001,
      st_park = 3'b010,
      st_swap = 3'b100
   } rsd_sw_state_e;

endpackage

//--- hw/rsd_out_div.sv
// one output divider: disable, bypass, divide by 2 or by (q+2)*2
// assumes src_level is a sampled clock level on ref_clk
`timescale 1ns/100ps
`default_nettype none
`include "rsd_defs.svh"

module rsd_out_div (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // source and setting
   input  wire logic       src_level,
   input  wire logic [6:0] div_count,
   input  wire logic       path_bit,
   input  wire logic [1:0] disabled_state,
   // output pin
   output logic            clk_out,
   output logic            clk_oe
);

   logic       src_prev_q;
   logic [6:0] cnt_q;
   logic       out_q;
   logic       oe_q;
   logic       all_ones;
   logic       disabled;
   logic       bypass;
   logic       rise;

   assign all_ones = (div_count == `RSD_Q_ALLONES);
   assign disabled = all_ones && !path_bit;
   assign bypass   = all_ones && path_bit;
   assign rise     = src_level && !src_prev_q;
   assign clk_out  = out_q;
   assign clk_oe   = oe_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_level;
      end
   end

   // stopped but powered while disabled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= 7'h00;
         out_q <= 1'b0;
      end else if (disabled) begin
         cnt_q <= 7'h00;
         out_q <= (disabled_state == `RSD_DIS_HIGH);
      end else if (bypass) begin
         cnt_q <= 7'h00;
         out_q <= src_level;
      end else if (rise) begin
         if (!path_bit) begin
            out_q <= !out_q;
         end else if (cnt_q >= div_count + 7'h01) begin
            // q+2 source edges per half period, up to 256 overall
            cnt_q <= 7'h00;
            out_q <= !out_q;
         end else begin
            cnt_q <= cnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         oe_q <= 1'b1;
      end else begin
         oe_q <= !(disabled && disabled_state[`RSD_DIS_HIZ]);
      end
   end

   disabled_low_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (disabled && disabled_state == `RSD_DIS_LOW) [*2]
      |-> (!clk_out && clk_oe))
      else $error("disabled divider not held low");

   divided_edge_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (!all_ones && $past(!all_ones) && !$past(rst) && $changed(clk_out))
      |-> $past(rise))
      else $error("divided output moved without a source edge");

endmodule
`default_nettype wire

//--- hw/rsd_ref_select.sv
// reference selection, loss of primary, switchover and divider setup
// assumes an avalon-mm master on ref_clk; reference pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "rsd_defs.svh"

module rsd_ref_select (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // avalon-mm slave
   input  wire logic [`RSD_ADDR_W-1:0]   avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   // reference pins
   input  wire logic                     crystal_ref_input,
   input  wire logic                     aux_clock_input,
   input  wire logic                     input_select_pin,
   // clock outputs
   output logic                          undivided_output,
   output logic [5:0]                    div_out,
   output logic [5:0]                    div_out_oe
);

   rsd_pkg::rsd_sw_state_e sw_state_q;
   logic [`RSD_CTRL_W-1:0] ctrl_q;
   logic [`RSD_PLL_W-1:0]  pll_q   [4];
   logic [`RSD_ODIV_W-1:0] odiv_q  [6];
   logic [31:0]            rdata_q;
   logic                   ack_q;
   logic [2:0]             pin_s1_q, pin_s2_q, pin_s3_q;
   logic [2:0]             pin_f_q;
   logic [1:0]             ref_prev_q;
   logic [1:0]             sec_cnt_q;
   logic                   lost_q, cur_sec_q, ref_out_q;

   logic [`RSD_IDX_W-1:0]  idx;
   logic                   wr_fire;
   logic [31:0]            wmask;
   logic [31:0]            rd_mux;
   logic                   load_cap_trim_f, aux_f, sel_f;
   logic                   pri_f, sec_f, pri_edge, sec_edge;
   logic                   auto_mode, want_sec, cur_ref;
   logic [`RSD_PLL_M_W-1:0] pll_m  [4];
   logic [3:0]             pll_pd, pll_bad;
   logic [5:0]             cap_eighths;

   assign idx             = avs_address[`RSD_ADDR_W-1:2];
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_fire         = avs_write && !avs_waitrequest;
   assign avs_readdata    = rdata_q;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // one wait cycle, then the access completes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= `RSD_CTRL_RST;
      end else if (wr_fire && idx == `RSD_IDX_CTRL) begin
         ctrl_q <= (ctrl_q & ~wmask[`RSD_CTRL_W-1:0])
                 | (avs_writedata[`RSD_CTRL_W-1:0] & wmask[`RSD_CTRL_W-1:0]);
      end
   end

   // divider fields: 7-bit reference, 12-bit feedback, 4-bit adjust
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            pll_q[i] <= `RSD_PLL_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_fire && idx == `RSD_IDX_PLLCFG + 4'(i)) begin
               pll_q[i] <= (pll_q[i] & ~wmask[`RSD_PLL_W-1:0])
                 | (avs_writedata[`RSD_PLL_W-1:0] & wmask[`RSD_PLL_W-1:0]);
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 6; i++) begin
            odiv_q[i] <= `RSD_ODIV_RST;
         end
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (wr_fire && idx == `RSD_IDX_ODIV + 4'(i)) begin
               odiv_q[i] <= (odiv_q[i] & ~wmask[`RSD_ODIV_W-1:0])
                 | (avs_writedata[`RSD_ODIV_W-1:0] & wmask[`RSD_ODIV_W-1:0]);
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pll_m[i] = `RSD_PLL_M_W'(pll_q[i][`RSD_PLL_N]);
      end
      if (pll_q[0][`RSD_PLL_A] != 4'h0) begin
         pll_m[0] = `RSD_PLL_M_W'({pll_q[0][`RSD_PLL_N], 1'b0})
                  + `RSD_PLL_M_W'(pll_q[0][`RSD_PLL_A])
                  + `RSD_PLL_M_W'(1);
      end else begin
         pll_m[0] = `RSD_PLL_M_W'({pll_q[0][`RSD_PLL_N], 1'b0});
      end
      for (int i = 0; i < 3; i++) begin
         pll_pd[i]  = (pll_q[i][`RSD_PLL_D] == 7'h00);
         pll_bad[i] = 1'b0;
      end
      pll_pd[3]  = 1'b0;
      pll_bad[3] = (pll_q[3][`RSD_PLL_D] < `RSD_PLL3_D_MIN);
   end

   assign cap_eighths = `RSD_CAP_BASE + {1'b0, ctrl_q[`RSD_CTRL_TRIM]};

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (idx == `RSD_IDX_CTRL) begin
         rd_mux[`RSD_CTRL_W-1:0] = ctrl_q;
      end else if (idx == `RSD_IDX_STATUS) begin
         rd_mux[11:0] = {sw_state_q, cap_eighths,
                         auto_mode && ctrl_q[`RSD_CTRL_PSS],
                         lost_q, cur_sec_q};
      end else if (idx >= `RSD_IDX_PLLCFG && idx < `RSD_IDX_PLLST) begin
         rd_mux[`RSD_PLL_W-1:0] = pll_q[2'(idx - `RSD_IDX_PLLCFG)];
      end else if (idx >= `RSD_IDX_PLLST && idx < `RSD_IDX_ODIV) begin
         rd_mux[15:0] = {pll_bad[2'(idx - `RSD_IDX_PLLST)],
                         pll_pd[2'(idx - `RSD_IDX_PLLST)],
                         pll_m[2'(idx - `RSD_IDX_PLLST)]};
      end else if (idx >= `RSD_IDX_ODIV) begin
         rd_mux[`RSD_ODIV_W-1:0] = odiv_q[3'(idx - `RSD_IDX_ODIV)];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {pin_s3_q, pin_s2_q, pin_s1_q} <= 9'h000;
         pin_f_q  <= 3'h0;
      end else begin
         {pin_s3_q, pin_s2_q, pin_s1_q} <= {pin_s2_q, pin_s1_q,
            input_select_pin, aux_clock_input, crystal_ref_input};
         for (int i = 0; i < 3; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_f_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   assign load_cap_trim_f = pin_f_q[0];
   assign aux_f  = pin_f_q[1];
   assign sel_f  = pin_f_q[2];
   assign pri_f  = ctrl_q[`RSD_CTRL_PSS] ? aux_f : load_cap_trim_f;
   assign sec_f  = ctrl_q[`RSD_CTRL_PSS] ? load_cap_trim_f : aux_f;
   assign pri_edge = pri_f && !ref_prev_q[0];
   assign sec_edge = sec_f && !ref_prev_q[1];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_prev_q <= 2'b00;
      end else begin
         ref_prev_q <= {sec_f, pri_f};
      end
   end

   // sound only while secondary is no faster than primary
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sec_cnt_q <= 2'h0;
         lost_q    <= 1'b0;
      end else if (pri_edge) begin
         sec_cnt_q <= 2'h0;
         lost_q    <= 1'b0;
      end else if (sec_edge && sec_cnt_q != `RSD_LOSS_CNT) begin
         sec_cnt_q <= sec_cnt_q + 2'h1;
         if (sec_cnt_q + 2'h1 == `RSD_LOSS_CNT) begin
            lost_q <= 1'b1;
         end
      end
   end

   assign auto_mode = ctrl_q[`RSD_CTRL_AUTO];
   assign cur_ref   = cur_sec_q ? sec_f : pri_f;

   // crystal-driven input is assumed absent from switching setups
   always_comb begin
      if (!auto_mode) begin
         want_sec = sel_f;
      end else if (!ctrl_q[`RSD_CTRL_PSS]) begin
         want_sec = lost_q;
      end else begin
         want_sec = 1'b0;
      end
   end

   // park until the old source is low, or at once on primary loss, then wait for the new one low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sw_state_q <= rsd_pkg::st_run;
         cur_sec_q  <= 1'b0;
      end else begin
         unique case (sw_state_q)
            rsd_pkg::st_run: begin
               if (want_sec != cur_sec_q) begin
                  sw_state_q <= rsd_pkg::st_park;
               end
            end
            rsd_pkg::st_park: begin
               if (!cur_ref || (lost_q && !cur_sec_q)) begin
                  cur_sec_q  <= want_sec;
                  sw_state_q <= rsd_pkg::st_swap;
               end
            end
            rsd_pkg::st_swap: begin
               if (!cur_ref) begin
                  sw_state_q <= rsd_pkg::st_run;
               end
            end
            default: begin
               sw_state_q <= rsd_pkg::st_run;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_out_q <= 1'b0;
      end else if (sw_state_q == rsd_pkg::st_swap) begin
         ref_out_q <= 1'b0;
      end else begin
         ref_out_q <= cur_ref;
      end
   end

   assign undivided_output = ref_out_q;

   for (genvar g = 0; g < 6; g++) begin : g_odiv
      rsd_out_div u_div (
         .ref_clk        (ref_clk),
         .rst            (rst),
         .src_level      (ref_out_q),
         .div_count      (odiv_q[g][`RSD_ODIV_Q]),
         .path_bit       (odiv_q[g][`RSD_ODIV_PATH]),
         .disabled_state (odiv_q[g][`RSD_ODIV_DIS]),
         .clk_out        (div_out[g]),
         .clk_oe         (div_out_oe[g])
      );
   end

   first_synth_loop_total_a: assert property (@(posedge ref_clk) disable iff (rst)
      pll_m[0] == ((pll_q[0][`RSD_PLL_A] != 4'h0) ?
         `RSD_PLL_M_W'(2 * pll_q[0][`RSD_PLL_N] + pll_q[0][`RSD_PLL_A] + 1)
       : `RSD_PLL_M_W'(2 * pll_q[0][`RSD_PLL_N])))
      else $error("first loop total feedback wrong");
   pll_plain_a: assert property (@(posedge ref_clk) disable iff (rst)
      pll_m[3] == `RSD_PLL_M_W'(pll_q[3][`RSD_PLL_N])
      && pll_m[1] == `RSD_PLL_M_W'(pll_q[1][`RSD_PLL_N]))
      else $error("plain loop feedback wrong");
   pll_down_a: assert property (@(posedge ref_clk) disable iff (rst)
      pll_pd[2] == (pll_q[2][`RSD_PLL_D] == 7'h00)
      && pll_bad[3] == (pll_q[3][`RSD_PLL_D] <= 7'h02))
      else $error("power down or illegal divide flag wrong");
   load_cap_a: assert property (@(posedge ref_clk) disable iff (rst)
      cap_eighths == 6'(28 + ctrl_q[`RSD_CTRL_TRIM]))
      else $error("load capacitance code wrong");
   loss_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      (sec_edge && sec_cnt_q == 2'h1 && !pri_edge) |=> lost_q)
      else $error("primary loss not flagged");
   revert_a: assert property (@(posedge ref_clk) disable iff (rst)
      pri_edge |=> (!lost_q && sec_cnt_q == 2'h0))
      else $error("primary edge did not clear loss");
   aux_no_auto_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (auto_mode && ctrl_q[`RSD_CTRL_PSS]) |-> !want_sec)
      else $error("auto switch with aux primary");
   swap_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
      $changed(cur_sec_q) |-> sw_state_q == rsd_pkg::st_swap ##1 !ref_out_q)
      else $error("output not parked at switchover");
   manual_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!auto_mode && sw_state_q == rsd_pkg::st_run && sel_f != cur_sec_q)
      |=> sw_state_q == rsd_pkg::st_park)
      else $error("manual select not acted on");
   bus_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("waitrequest held more than one cycle");

endmodule
`default_nettype wire

//--- tb/rsd_ref_src.sv
// behavioural reference sources for the reference select block
// assumes the bench gates each source with a run level
`timescale 1ns/100ps
`default_nettype none

module rsd_ref_src #(
   parameter int LOAD_CAP_TRIM_HALF = 40,
   parameter int AUX_HALF  = 73
) (
   // run controls
   input  wire logic load_cap_trim_run,
   input  wire logic aux_run,
   // reference pins
   output logic      crystal_ref_input,
   output logic      aux_clock_input
);
   // oscillators, never a crystal, feed both pins
   // the secondary runs slower than the crystal input primary
   // a stopped source stands low, as an idle oscillator output
   initial crystal_ref_input = 1'b0;
   initial aux_clock_input = 1'b0;
   always begin
      #(LOAD_CAP_TRIM_HALF);
      crystal_ref_input = load_cap_trim_run ? ~crystal_ref_input : 1'b0;
   end
   always begin
      #(AUX_HALF);
      aux_clock_input = aux_run ? ~aux_clock_input : 1'b0;
   end
endmodule
`default_nettype wire

//--- tb/test_rsd_ref_select.sv
// self-checking bench for the reference select and divider block
// assumes rsd_ref_src drives the reference pins
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp, msg) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
   end \
end

module test_rsd_ref_select;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        crystal_ref_input;
   logic        aux_clock_input;
   logic        input_select_pin = 1'b0;
   logic        undivided_output;
   logic [5:0]  div_out;
   logic [5:0]  div_out_oe;
   logic        load_cap_trim_run = 1'b1;
   logic        aux_run = 1'b1;
   logic [15:0] lfsr = 16'h525f;
   int          num_errors = 0;
   int          n_tests = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          und_r = 0;
   int          div_r = 0;
   int          hi_len = 0;
   logic        und_d = 1'b0;
   logic        div_d = 1'b0;
   logic        glitch_on = 1'b0;
   logic [11:0] nf;
   logic [3:0]  af;
   logic [6:0]  df;
   logic [13:0] m;
   logic [31:0] e0;
   int          lp;

   always #5 ref_clk = ~ref_clk;

   rsd_ref_select u_rsd_ref_select (
      .ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .crystal_ref_input(crystal_ref_input),
      .aux_clock_input(aux_clock_input),
      .input_select_pin(input_select_pin),
      .undivided_output(undivided_output),
      .div_out(div_out), .div_out_oe(div_out_oe)
   );

   rsd_ref_src u_rsd_ref_src (
      .load_cap_trim_run(load_cap_trim_run), .aux_run(aux_run),
      .crystal_ref_input(crystal_ref_input),
      .aux_clock_input(aux_clock_input)
   );

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one avalon transfer, held until waitrequest is sampled low at an edge
   task automatic bus(input logic is_rd, input logic [5:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_read       <= is_rd;
      avs_write      <= !is_rd;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         num_errors++;
         end_of_test();
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 4'hf);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] mk);
      exp_q.push_back(e & mk);
      msk_q.push_back(mk);
      bus(1'b1, a, 32'h0000_0000, 4'hf);
   endtask

   // program output one, then count its edges against the reference
   task automatic ratio_chk(input logic [6:0] q, input logic p,
                            input int r);
      wr(6'h28, {22'h00_0000, 2'b00, p, q});
      repeat (50) @(posedge ref_clk);
      und_r = 0;
      div_r = 0;
      // a slow ratio needs several output periods inside the window
      repeat ((r > 16) ? 8400 : 1200) @(posedge ref_clk);
      `CHK((r == 0) ? (div_r == 0) : (und_r >= r * div_r - r - 1 &&
           und_r <= r * div_r + r + 1), 1'b1, "divide ratio")
   endtask

   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0, "unexpected read")
         end else begin
            `CHK(avs_readdata & msk_q[0], exp_q[0], "read data")
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end
   end

   // edge counters on the selected reference and output one, short-pulse watch on the reference
   always @(posedge ref_clk) begin
      und_d <= undivided_output;
      div_d <= div_out[0];
      if (undivided_output && !und_d)
         und_r++;
      if (div_out[0] && !div_d)
         div_r++;
      if (undivided_output === 1'b1) begin
         hi_len++;
      end else begin
         if (und_d && glitch_on)
            `CHK(hi_len > 1, 1'b1, "short pulse")
         hi_len = 0;
      end
   end

   initial begin
      #1_000_000;
      num_errors++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      rd(6'h00, 32'h0000_0300, 32'hffff_ffff);
      rd(6'h08, 32'h0000_0001, 32'hffff_ffff);
      rd(6'h28, 32'h0000_0000, 32'hffff_ffff);
      wr(6'h00, 32'h0000_03f8);
      rd(6'h04, 32'h0000_01d8, 32'h0000_01f8);
      // byte write puts trim back to zero for the external reference
      bus(1'b0, 6'h00, 32'hffff_ff00, 4'b0001);
      rd(6'h00, 32'h0000_0300, 32'hffff_ffff);
      for (int k = 0; k < 12; k++) begin
         lfsr = lfsr_next(lfsr);
         lp = k % 4;
         nf = lfsr[11:0];
         af = (k < 4) ? 4'h0 : lfsr[15:12];
         df = (k >= 8) ? {5'h00, lfsr[1:0]} : (lfsr[6:0] | 7'h03);
         m = (lp != 0) ? {2'b00, nf} :
             {1'b0, nf, 1'b0} + {10'h000, af} + {13'h0000, af != 4'h0};
         wr(6'(8 + 4 * lp), {9'h000, af, nf, df});
         e0 = {16'h0000, lp == 3 && df < 7'h03, lp < 3 && df == 7'h00, m};
         rd(6'(24 + 4 * lp), e0, 32'h0000_ffff);
      end
      wr(6'h24, 32'hffff_ffff);
      rd(6'h24, e0, 32'h0000_ffff);
      glitch_on = 1'b1;
      repeat (300) @(posedge ref_clk);
      rd(6'h04, 32'h0000_0000, 32'h0000_0001);
      input_select_pin <= 1'b1;
      repeat (300) @(posedge ref_clk);
      rd(6'h04, 32'h0000_0001, 32'h0000_0001);
      input_select_pin <= 1'b0;
      repeat (300) @(posedge ref_clk);
      glitch_on = 1'b0;
      wr(6'h00, 32'h0000_0304);
      load_cap_trim_run <= 1'b0;
      repeat (300) @(posedge ref_clk);
      rd(6'h04, 32'h0000_0003, 32'h0000_0003);
      load_cap_trim_run <= 1'b1;
      repeat (300) @(posedge ref_clk);
      rd(6'h04, 32'h0000_0000, 32'h0000_0003);
      wr(6'h00, 32'h0000_0305);
      rd(6'h04, 32'h0000_0004, 32'h0000_0004);
      wr(6'h00, 32'h0000_0300);
      ratio_chk(7'h7f, 1'b1, 1);
      ratio_chk(7'h7f, 1'b0, 0);
      ratio_chk(7'h00, 1'b0, 2);
      ratio_chk(7'h01, 1'b1, 6);
      ratio_chk(7'h7e, 1'b1, 256);
      // output one stands for a bank never used in normal running
      for (int s = 0; s < 4; s++) begin
         wr(6'h28, {22'h00_0000, 2'(s), 1'b0, 7'h7f});
         repeat (20) @(posedge ref_clk);
         if (s < 2)
            `CHK(div_out[0], s == 1, "held level")
         `CHK(div_out_oe[0], s < 2, "output enable")
      end
      `CHK(div_out_oe[5:1], 5'h1f, "other outputs enabled")
      end_of_test();
   end
endmodule
`default_nettype wire
